// >>> ldl_top.sv
// Loop closure / ring trip detect status, debounce intervals and linefeed
// parameter registers behind an AXI4-Lite slave, with one interrupt line.
// Assumes comparator inputs are asynchronous pins; auto_diff_code_i comes
// from same-clock linefeed logic.
`timescale 1ns/1ps
`include "ldl_defines.svh"

// Notes on behaviour
// - Status bit 2 shows live combined comparator output, 0 when a threshold is exceeded.
// - Status bit 1 shows debounced ring trip, 1 once detected.
// - Status bit 0 shows debounced loop closure, 1 once detected.
// - Seven-bit loop closure settle time, code times 1.25 ms, reset 12.5 ms.
// - Seven-bit ring trip settle time, code times 1.25 ms, reset 12.5 ms.
// - Three-bit feed current code: 20 mA plus 3 mA per step.
// - On-hook polarity bit 6: 0 positive, 1 negative tip minus ring.
// - Six-bit on-hook voltage in 1.5 V steps, 48 V after reset.
// - Six-bit common-mode voltage in negative 1.5 V steps.
// - Six-bit high battery voltage in negative 1.5 V steps, reset -75 V.
// - Auto enables move linefeed to active on debounced closure or trip.
// - Manual differential select makes differential follow on-hook voltage setting.
module ldl_top
    import ldl_pkg::*;
#(
    parameter int STEP_CYCLES = `LDL_STEP_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic [11:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [11:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        loop_closure_cmp_i,
    input  wire logic        ring_trip_cmp_i,
    input  wire logic [6:0]  auto_diff_code_i,
    output ldl_feed_t        feed_o,
    output logic [2:0]       linefeed_state_o,
    output logic             diff_manual_o,
    output logic [6:0]       diff_code_o,
    output logic             irq_o
);
    // Comparator synchronisers; stage one is read only by stage two
    logic [1:0] cmp_meta_r, cmp_sync_r;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cmp_meta_r <= '0;
            cmp_sync_r <= '0;
        end else begin
            cmp_meta_r <= {ring_trip_cmp_i, loop_closure_cmp_i};
            cmp_sync_r <= cmp_meta_r;
        end
    end

    logic raw_detect_level;
    logic loop_closed_seen;
    logic ring_trip_seen;
    assign raw_detect_level = ~(cmp_sync_r[0] | cmp_sync_r[1]);

    // Register storage
    logic [6:0] loop_closure_settle_time_r, ring_trip_settle_time_r;
    logic [6:0] lc_deb_nxt, rt_deb_nxt;
    ldl_feed_t  feed_r, feed_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [2:0] linefeed_r, linefeed_nxt;
    logic [1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic       irq_r, irq_nxt;
    logic       diff_man_r, diff_man_nxt;
    logic [6:0] diff_code_r, diff_code_nxt;
    logic       lc_seen_d_r, rt_seen_d_r;

    // One debouncer per detector
    ldl_debounce #(.TICK_CYCLES(STEP_CYCLES)) u_lc_deb (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .code_i    (loop_closure_settle_time_r),
        .raw_i     (cmp_sync_r[0]),
        .filt_o    (loop_closed_seen)
    );
    ldl_debounce #(.TICK_CYCLES(STEP_CYCLES)) u_rt_deb (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .code_i    (ring_trip_settle_time_r),
        .raw_i     (cmp_sync_r[1]),
        .filt_o    (ring_trip_seen)
    );

    logic lc_rise, rt_rise;
    assign lc_rise = loop_closed_seen & ~lc_seen_d_r;
    assign rt_rise = ring_trip_seen & ~rt_seen_d_r;

    // Write channel: address and data held until both are in
    logic        aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [9:0]  aw_idx_r, aw_idx_nxt;
    logic [7:0]  wbyte_r, wbyte_nxt;
    logic        wen_r, wen_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        commit;
    logic        wr_hit;

    assign commit = aw_full_r & w_full_r & ~bvalid_r;

    always_comb begin
        case (aw_idx_r)
            `LDL_IDX_DETECT, `LDL_IDX_LC_DEB, `LDL_IDX_RT_DEB, `LDL_IDX_FEED,
            `LDL_IDX_ONHOOK, `LDL_IDX_CMODE, `LDL_IDX_HBAT, `LDL_IDX_CTRL,
            `LDL_IDX_LINEFEED, `LDL_IDX_IRQ_STAT, `LDL_IDX_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write handshake next state; a new beat may land while a response waits
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt  = w_full_r;
        aw_idx_nxt  = aw_idx_r;
        wbyte_nxt   = wbyte_r;
        wen_nxt     = wen_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (bvalid_r && s_axi_bready_i) begin
            bvalid_nxt = 1'b0;
        end
        if (commit) begin
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? `LDL_RESP_OKAY : `LDL_RESP_SLVERR;
        end
        if (s_axi_awvalid_i && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            aw_idx_nxt  = s_axi_awaddr_i[11:2];
        end
        if (s_axi_wvalid_i && !w_full_r) begin
            w_full_nxt = 1'b1;
            wbyte_nxt  = s_axi_wdata_i[7:0];
            wen_nxt    = s_axi_wstrb_i[0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_idx_r  <= '0;
            wbyte_r   <= '0;
            wen_r     <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `LDL_RESP_OKAY;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            aw_idx_r  <= aw_idx_nxt;
            wbyte_r   <= wbyte_nxt;
            wen_r     <= wen_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

    // Ready is low exactly while a beat is held, so it is a plain flop state
    assign s_axi_awready_o = ~aw_full_r;
    assign s_axi_wready_o  = ~w_full_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;

    // Register file next values; hardware events win over software writes
    logic wr_go;
    assign wr_go = commit & wen_r;

    always_comb begin
        lc_deb_nxt    = loop_closure_settle_time_r;
        rt_deb_nxt    = ring_trip_settle_time_r;
        feed_nxt      = feed_r;
        ctrl_nxt      = ctrl_r;
        linefeed_nxt  = linefeed_r;
        irq_stat_nxt  = irq_stat_r;
        irq_mask_nxt  = irq_mask_r;
        if (wr_go) begin
            case (aw_idx_r)
                `LDL_IDX_LC_DEB:   lc_deb_nxt = wbyte_r[6:0];
                `LDL_IDX_RT_DEB:   rt_deb_nxt = wbyte_r[6:0];
                `LDL_IDX_FEED:     feed_nxt.feed_current_code = wbyte_r[2:0];
                `LDL_IDX_ONHOOK: begin
                    feed_nxt.on_hook_polarity     = wbyte_r[6];
                    feed_nxt.on_hook_voltage_code = wbyte_r[5:0];
                end
                `LDL_IDX_CMODE:    feed_nxt.common_mode_code = wbyte_r[5:0];
                `LDL_IDX_HBAT:     feed_nxt.high_battery_code = wbyte_r[5:0];
                `LDL_IDX_CTRL:     ctrl_nxt = wbyte_r & 8'h26;  // Reserved bits stay zero
                `LDL_IDX_LINEFEED: linefeed_nxt = wbyte_r[2:0];
                `LDL_IDX_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wbyte_r[1:0];
                `LDL_IDX_IRQ_MASK: irq_mask_nxt = wbyte_r[1:0];
                default: ;
            endcase
        end
        // Automatic entry to forward active on a fresh detection
        if ((lc_rise && ctrl_r[`LDL_CTRL_AUTO_LC]) ||
            (rt_rise && ctrl_r[`LDL_CTRL_AUTO_RT])) begin
            linefeed_nxt = `LDL_LF_FWD_ACTIVE;
        end
        if (lc_rise) begin
            irq_stat_nxt[`LDL_IRQ_LC] = 1'b1;
        end
        if (rt_rise) begin
            irq_stat_nxt[`LDL_IRQ_RT] = 1'b1;
        end
        irq_nxt       = |(irq_stat_nxt & irq_mask_nxt);
        diff_man_nxt  = ctrl_nxt[`LDL_CTRL_MAN_DIFF];
        diff_code_nxt = diff_man_nxt ?
                        {feed_nxt.on_hook_polarity, feed_nxt.on_hook_voltage_code} :
                        auto_diff_code_i;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            loop_closure_settle_time_r <= `LDL_RST_LC_DEB;
            ring_trip_settle_time_r    <= `LDL_RST_RT_DEB;
            feed_r.feed_current_code   <= `LDL_RST_FEED;
            feed_r.on_hook_polarity    <= 1'(`LDL_RST_ONHOOK >> `LDL_ONHOOK_POL_BIT);
            feed_r.on_hook_voltage_code <= 6'(`LDL_RST_ONHOOK);
            feed_r.common_mode_code    <= `LDL_RST_CMODE;
            feed_r.high_battery_code   <= `LDL_RST_HBAT;
            ctrl_r                     <= `LDL_RST_CTRL;
            linefeed_r                 <= `LDL_RST_LINEFEED;
            irq_stat_r                 <= '0;
            irq_mask_r                 <= '0;
            irq_r                      <= 1'b0;
            diff_man_r                 <= 1'b0;
            diff_code_r                <= '0;
            lc_seen_d_r                <= 1'b0;
            rt_seen_d_r                <= 1'b0;
        end else begin
            loop_closure_settle_time_r <= lc_deb_nxt;
            ring_trip_settle_time_r    <= rt_deb_nxt;
            feed_r                     <= feed_nxt;
            ctrl_r                     <= ctrl_nxt;
            linefeed_r                 <= linefeed_nxt;
            irq_stat_r                 <= irq_stat_nxt;
            irq_mask_r                 <= irq_mask_nxt;
            irq_r                      <= irq_nxt;
            diff_man_r                 <= diff_man_nxt;
            diff_code_r                <= diff_code_nxt;
            lc_seen_d_r                <= loop_closed_seen;
            rt_seen_d_r                <= ring_trip_seen;
        end
    end

    assign feed_o           = feed_r;
    assign linefeed_state_o = linefeed_r;
    assign diff_manual_o    = diff_man_r;
    assign diff_code_o      = diff_code_r;
    assign irq_o            = irq_r;

    // Read channel: one read at a time, data captured into a flop
    ldl_rd_state_t rd_state_r, rd_state_nxt;
    logic [31:0]   rdata_r, rdata_nxt;
    logic [1:0]    rresp_r, rresp_nxt;
    logic [7:0]    rd_byte;
    logic          rd_hit;

    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr_i[11:2])
            `LDL_IDX_DETECT:   rd_byte = {5'h00, raw_detect_level,
                                          ring_trip_seen, loop_closed_seen};
            `LDL_IDX_LC_DEB:   rd_byte = {1'b0, loop_closure_settle_time_r};
            `LDL_IDX_RT_DEB:   rd_byte = {1'b0, ring_trip_settle_time_r};
            `LDL_IDX_FEED:     rd_byte = {5'h00, feed_r.feed_current_code};
            `LDL_IDX_ONHOOK:   rd_byte = {1'b0, feed_r.on_hook_polarity,
                                          feed_r.on_hook_voltage_code};
            `LDL_IDX_CMODE:    rd_byte = {2'h0, feed_r.common_mode_code};
            `LDL_IDX_HBAT:     rd_byte = {2'h0, feed_r.high_battery_code};
            `LDL_IDX_CTRL:     rd_byte = ctrl_r;
            `LDL_IDX_LINEFEED: rd_byte = {5'h00, linefeed_r};
            `LDL_IDX_IRQ_STAT: rd_byte = {6'h00, irq_stat_r};
            `LDL_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_r};
            default:           rd_hit  = 1'b0;
        endcase
    end

    // Read handshake next state
    always_comb begin
        rd_state_nxt = rd_state_r;
        rdata_nxt    = rdata_r;
        rresp_nxt    = rresp_r;
        case (rd_state_r)
            RD_IDLE: begin
                if (s_axi_arvalid_i) begin
                    rd_state_nxt = RD_DATA;
                    rdata_nxt    = {24'h000000, rd_byte};
                    rresp_nxt    = rd_hit ? `LDL_RESP_OKAY : `LDL_RESP_SLVERR;
                end
            end
            RD_DATA: begin
                if (s_axi_rready_i) begin
                    rd_state_nxt = RD_IDLE;
                end
            end
            default: rd_state_nxt = RD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rd_state_r <= RD_IDLE;
            rdata_r    <= '0;
            rresp_r    <= `LDL_RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
        end
    end

    assign s_axi_arready_o = (rd_state_r == RD_IDLE);
    assign s_axi_rvalid_o  = (rd_state_r == RD_DATA);
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    a_raw_level_pins: assert property (
        (!$past(reset_i, 1) && !$past(reset_i, 2)) |->
        raw_detect_level == !($past(loop_closure_cmp_i, 2) || $past(ring_trip_cmp_i, 2)))
        else $error("raw detect level does not follow comparators");
    a_lc_follows_raw: assert property (
        $changed(loop_closed_seen) |-> loop_closed_seen == $past(cmp_sync_r[0]))
        else $error("loop closure indicator moved away from raw level");
    a_rt_follows_raw: assert property (
        $changed(ring_trip_seen) |-> ring_trip_seen == $past(cmp_sync_r[1]))
        else $error("ring trip indicator moved away from raw level");
    a_zero_code_pass: assert property (
        (loop_closure_settle_time_r == 7'h00 && cmp_sync_r[0] != loop_closed_seen)
        |=> loop_closed_seen == $past(cmp_sync_r[0]))
        else $error("zero settle time did not pass change at once");
    a_settle_hold: assert property (
        (loop_closure_settle_time_r != 7'h00 && cmp_sync_r[0] != loop_closed_seen &&
         $past(cmp_sync_r[0]) == $past(loop_closed_seen)) |=>
        (loop_closed_seen == $past(loop_closed_seen)) [*2])
        else $error("loop closure indicator changed before settle time");
    a_auto_active: assert property (
        (lc_rise && ctrl_r[`LDL_CTRL_AUTO_LC]) |=> linefeed_r == `LDL_LF_FWD_ACTIVE)
        else $error("linefeed not moved to active on loop closure");
    a_manual_diff: assert property (
        (diff_man_r && $stable(feed_r)) |->
        diff_code_o == {feed_r.on_hook_polarity, feed_r.on_hook_voltage_code})
        else $error("manual differential does not follow on-hook setting");
    a_feed_code_write: assert property (
        (wr_go && aw_idx_r == `LDL_IDX_FEED) |=> feed_o.feed_current_code == $past(wbyte_r[2:0]))
        else $error("feed current code not stored");
    a_onhook_write: assert property (
        (wr_go && aw_idx_r == `LDL_IDX_ONHOOK) |=>
        {feed_o.on_hook_polarity, feed_o.on_hook_voltage_code} == $past(wbyte_r[6:0]))
        else $error("on-hook setting not stored");
    a_irq_level: assert property (
        irq_o == |(irq_stat_r & irq_mask_r))
        else $error("interrupt output disagrees with status and mask");
    a_bvalid_hold: assert property (
        (bvalid_r && !s_axi_bready_i) |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped before taken");

    c_loop_closure: cover property (lc_rise);
    c_ring_trip_auto: cover property (rt_rise && ctrl_r[`LDL_CTRL_AUTO_RT]);
    c_write_read: cover property (commit ##[1:20] (rd_state_r == RD_DATA && s_axi_rready_i));

endmodule : ldl_top

// >>> ldl_defines.svh
// Register indices, field layouts, reset values and timing for the loop detect
// and linefeed parameter bank.
// Assumes a 200 MHz system clock; byte address of a register is its index times four.
`ifndef LDL_DEFINES_SVH
`define LDL_DEFINES_SVH

// Register indices (byte address = index * 4)
`define LDL_IDX_DETECT      10'h044
`define LDL_IDX_LC_DEB      10'h045
`define LDL_IDX_RT_DEB      10'h046
`define LDL_IDX_FEED        10'h047
`define LDL_IDX_ONHOOK      10'h048
`define LDL_IDX_CMODE       10'h049
`define LDL_IDX_HBAT        10'h04a
`define LDL_IDX_CTRL        10'h080
`define LDL_IDX_LINEFEED    10'h081
`define LDL_IDX_IRQ_STAT    10'h082
`define LDL_IDX_IRQ_MASK    10'h083

// Reset values
`define LDL_RST_LC_DEB      7'h0a
`define LDL_RST_RT_DEB      7'h0a
`define LDL_RST_FEED        3'h0
`define LDL_RST_ONHOOK      7'h20
`define LDL_RST_CMODE       6'h02
`define LDL_RST_HBAT        6'h32
`define LDL_RST_CTRL        8'h06
`define LDL_RST_LINEFEED    3'h0

// Control register bit positions
`define LDL_CTRL_AUTO_LC    1
`define LDL_CTRL_AUTO_RT    2
`define LDL_CTRL_MAN_DIFF   5

// On-hook register polarity bit
`define LDL_ONHOOK_POL_BIT  6

// Interrupt bit positions
`define LDL_IRQ_LC          0
`define LDL_IRQ_RT          1

// Linefeed state entered automatically on detection
`define LDL_LF_FWD_ACTIVE   3'h1

// AXI responses
`define LDL_RESP_OKAY       2'h0
`define LDL_RESP_SLVERR     2'h2

// Timing: debounce step and clock period, both in ns
`define LDL_STEP_NS         1250000
`define LDL_CLK_NS          5
`define LDL_STEP_CYCLES     (`LDL_STEP_NS / `LDL_CLK_NS)

`endif

// >>> ldl_pkg.sv
// Types shared by the loop detect and linefeed parameter bank.
// Assumes ldl_defines.svh supplies all numeric constants.
package ldl_pkg;

    // Linefeed settings handed to the analog feed circuits
    typedef struct packed {
        logic [2:0] feed_current_code;
        logic       on_hook_polarity;
        logic [5:0] on_hook_voltage_code;
        logic [5:0] common_mode_code;
        logic [5:0] high_battery_code;
    } ldl_feed_t;

    // Read channel state
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } ldl_rd_state_t;

endpackage : ldl_pkg

// >>> ldl_debounce.sv
// Debounce filter: output follows a synchronised input only after it held
// steady for code * step cycles. Assumes raw_i is already in the clock domain.
`timescale 1ns/1ps
`include "ldl_defines.svh"

module ldl_debounce #(
    parameter int TICK_CYCLES = `LDL_STEP_CYCLES
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic [6:0] code_i,
    input  wire logic       raw_i,
    output logic            filt_o
);
    logic [23:0] cyc_r, cyc_nxt;
    logic [6:0]  unit_r, unit_nxt;
    logic        filt_r, filt_nxt;

    // Count whole steps of disagreement; any agreement restarts the wait
    always_comb begin
        cyc_nxt  = '0;
        unit_nxt = '0;
        filt_nxt = filt_r;
        if (raw_i != filt_r) begin
            if (code_i == 7'h00) begin
                filt_nxt = raw_i;
            end else if (cyc_r == 24'(TICK_CYCLES - 1)) begin
                if (unit_r + 7'h01 >= code_i) begin
                    filt_nxt = raw_i;
                end else begin
                    unit_nxt = unit_r + 7'h01;
                end
            end else begin
                cyc_nxt  = cyc_r + 24'h000001;
                unit_nxt = unit_r;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cyc_r  <= '0;
            unit_r <= '0;
            filt_r <= 1'b0;
        end else begin
            cyc_r  <= cyc_nxt;
            unit_r <= unit_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign filt_o = filt_r;

endmodule : ldl_debounce

// >>> ldl_host.sv
// Host processor model: AXI4-Lite master with one write and one read task.
// Assumes one clock; a wait beyond 200 cycles raises hang for the bench.
`timescale 1ns/1ps
module ldl_host (
    input  wire logic        clk,
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic        rvalid,
    output logic             rready,
    output logic             hang
);
    // Idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, hang} = '0;
    end
    // Address and data go out together; each is dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'h1, 3'b111};
        for (n = 0; n < 200 && (awvalid || wvalid || !bvalid); n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (n >= 200) hang <= 1'b1;
    endtask : wr
    // Ready for data from the start, so the answer is taken where first seen
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 200 && (arvalid || !rvalid); n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (n >= 200) hang <= 1'b1;
    endtask : rd
endmodule : ldl_host

// >>> ldl_tb.sv
// Bench for the detect and linefeed register bank: reset values, masks,
// unmapped access, debounce, interrupts, auto linefeed, manual differential.
// Assumes STEP_CYCLES cut to 4, so one debounce step lasts 4 clocks.
`timescale 1ns/1ps
module tb;
    import ldl_pkg::*;
    logic        clk = 0, rst = 1, lc = 0, rt = 0, hang, irq, dman;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [6:0]  auto_c = 0, diff_c;
    logic [2:0]  lf;
    ldl_feed_t   feed;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          mismatches = 0, num_checks = 0;
    logic [11:0] adr[7] = '{12'h110, 12'h114, 12'h118, 12'h11c, 12'h120, 12'h124, 12'h128};
    logic [7:0]  rv[7] = '{8'h04, 8'h0a, 8'h0a, 8'h00, 8'h20, 8'h02, 8'h32};
    logic [7:0]  mk[7] = '{8'h00, 8'h7f, 8'h7f, 8'h07, 8'h7f, 8'h3f, 8'h3f};

    always #2.5 clk = ~clk;

    ldl_top #(.STEP_CYCLES(4)) ldl_top_i (
        .sys_clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .loop_closure_cmp_i(lc), .ring_trip_cmp_i(rt), .auto_diff_code_i(auto_c),
        .feed_o(feed), .linefeed_state_o(lf), .diff_manual_o(dman), .diff_code_o(diff_c),
        .irq_o(irq));

    ldl_host ldl_host_i (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid, .rready, .hang);

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // Each bus access notes its expected answer before it starts
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        rq.push_back({r, d});
        ldl_host_i.rd(a);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        bq.push_back(r);
        ldl_host_i.wr(a, d);
    endtask : wr
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Answer watcher: oldest note against each response as it is taken
    always @(posedge clk) begin
        if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
        if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (hang) begin
            mismatches++;
            test_done();
        end
    end

    // Overall limit in case a wait slips past the model's own bound
    initial begin
        cyc(20000);
        mismatches++;
        test_done();
    end

    initial begin
        logic [31:0] d[7];
        void'($urandom(64));
        cyc(16);
        rst <= 1'b0;
        // Reset values; raw level reads 1 while no threshold is exceeded
        for (int i = 0; i < 7; i++) rd(adr[i], rv[i]);
        // Random stores; reserved bits and the status register ignore them
        for (int i = 0; i < 7; i++) begin
            d[i] = $urandom | 32'h10;
            wr(adr[i], d[i]);
            rd(adr[i], (i == 0) ? 32'h4 : d[i] & mk[i]);
        end
        chk("feed", {d[3][2:0], d[4][6:0], d[5][5:0], d[6][5:0]}, feed);
        wr(12'h300, 32'hff, 2'h2);
        rd(12'h300, 32'h0, 2'h2);
        // Differential code follows the auto input until manual select
        auto_c <= 7'($urandom);
        cyc(3);
        chk("diff_auto", {1'b0, auto_c}, {dman, diff_c});
        wr(12'h200, 32'h26);
        cyc(2);
        chk("diff_man", {1'b1, d[4][6:0]}, {dman, diff_c});
        wr(12'h200, 32'h06);
        // Loop closure waits 8 clocks, ring trip passes at once
        wr(12'h114, 32'h2);
        wr(12'h118, 32'h0);
        wr(12'h20c, 32'h1);
        lc <= 1'b1;
        cyc(5);
        lc <= 1'b0;
        cyc(3);
        rd(12'h110, 32'h4);
        lc <= 1'b1;
        cyc(4);
        rd(12'h110, 32'h0);
        cyc(12);
        rd(12'h110, 32'h1);
        chk("irq_lc", 1'b1, irq);
        rd(12'h204, 32'h1);
        chk("linefeed", 34'h1, lf);
        lc <= 1'b0;
        wr(12'h208, 32'h1);
        wr(12'h204, 32'h0);
        cyc(12);
        rt <= 1'b1;
        cyc(4);
        rd(12'h110, 32'h2);
        chk("irq_masked", 1'b0, irq);
        rd(12'h204, 32'h1);
        chk("linefeed_rt", 34'h1, lf);
        wr(12'h20c, 32'h3);
        cyc(2);
        chk("irq_rt", 1'b1, irq);
        wr(12'h208, 32'h3);
        cyc(2);
        chk("irq_clear", 1'b0, irq);
        test_done();
    end
endmodule : tb
